// ==== sscr_params.svh ====
/*
 Constants of the sampling-synthesizer configuration register bank:
 serial frame layout, register offsets, reset values, field positions
 and mode codes. Assumes nothing; definitions only.
*/
`ifndef SSCR_PARAMS_SVH
`define SSCR_PARAMS_SVH

// ==========================================================
// Serial frame layout
`define SSCR_ADDR_W        15
`define SSCR_HDR_BITS      5'h10
`define SSCR_FRAME_BITS    5'h18

// ==========================================================
// Register offsets
`define SSCR_OFS_MODE      15'h0037
`define SSCR_OFS_TSTAMP    15'h003b
`define SSCR_OFS_REFO      15'h003c
`define SSCR_OFS_FBDIV12   15'h003d
`define SSCR_OFS_FBDIV3    15'h003e

// ==========================================================
// Reset values
`define SSCR_RST_MODE      8'h4b
`define SSCR_RST_TSTAMP    8'h00
`define SSCR_RST_REFO      8'h01
`define SSCR_RST_FBDIV12   8'h00
`define SSCR_RST_FBDIV3    8'h20

// ==========================================================
// Field positions and codes
`define SSCR_TS_RECV_BIT   0
`define SSCR_REFO_EN_BIT   0
`define SSCR_V_MSB         1
`define SSCR_V_LSB         0
`define SSCR_P_MSB         3
`define SSCR_P_LSB         2
`define SSCR_N_MSB         5
`define SSCR_N_LSB         0
`define SSCR_MODE_LOWPWR   8'h46
`define SSCR_MODE_HIPERF   8'h4b

`endif

// ==== sscr_pkg.sv ====
/*
 Types of the sampling-synthesizer configuration register bank.
 Assumes sscr_params.svh for the address width.
*/
`default_nettype none
`include "sscr_params.svh"

package sscr_pkg;

    // ==========================================================
    // Register access decoded from a serial frame
    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [`SSCR_ADDR_W-1:0]  addr;
        logic [7:0]               wdata;
    } sscr_req_t;

    // ==========================================================
    // Static settings driven into the converter core
    typedef struct packed {
        logic [7:0] code;
        logic       low_power;
        logic       high_perf;
        logic       reserved;
    } sscr_mode_cfg_t;

    typedef struct packed {
        logic [2:0] first_ratio;
        logic       first_reserved;
        logic [2:0] second_ratio;
        logic       second_reserved;
        logic [5:0] third_ratio;
    } sscr_synth_cfg_t;

    // ==========================================================
    // Module states
    typedef struct packed {
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic        sclk_prev;
        logic [4:0]  cnt;
        logic [22:0] sh_in;
        logic [7:0]  sh_out;
        logic        is_read;
        logic        sdo;
        logic        sdo_oe_n;
        sscr_req_t   req;
    } sscr_spi_st_t;

    typedef struct packed {
        logic [7:0]      mode;
        logic [7:0]      tstamp;
        logic [7:0]      refo;
        logic [7:0]      fbdiv12;
        logic [7:0]      fbdiv3;
        sscr_mode_cfg_t  mode_cfg;
        sscr_synth_cfg_t synth_cfg;
        logic            ts_recv_en;
        logic            refo_active;
    } sscr_regs_st_t;

endpackage
`default_nettype wire

// ==== sscr_spi_slave.sv ====
/*
 Serial control port slave. Frame, MSB first, sampled on sclk rising:
 read flag, 15 address bits, 8 data bits. Read data leaves on sclk falling.
 Assumes sclk at most clk_sys/8 and csn high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sscr_params.svh"

module sscr_spi_slave (
    input  wire logic               clk_sys,   // System clock
    input  wire logic               reset,     // Synchronous reset
    input  wire logic               sclk,      // Serial clock pin
    input  wire logic               csn,       // Chip select pin, low active
    input  wire logic               sdi,       // Serial data in pin
    output logic                    sdo,       // Serial data out
    output logic                    sdo_oe_n,  // Low while sdo drives
    output sscr_pkg::sscr_req_t     req,       // Register access pulse
    input  wire logic [7:0]         rd_data    // Data for the read pulse
);

    sscr_pkg::sscr_spi_st_t q;
    sscr_pkg::sscr_spi_st_t d;

    logic csn_s;
    logic sclk_s;
    logic sdi_s;

    assign csn_s  = q.sync2[2];
    assign sclk_s = q.sync2[1];
    assign sdi_s  = q.sync2[0];

    // ==========================================================
    // Frame decode
    always_comb begin
        d           = q;
        d.sync1     = {csn, sclk, sdi};
        d.sync2     = q.sync1;
        d.sclk_prev = sclk_s;
        d.req.wr    = 1'b0;
        d.req.rd    = 1'b0;
        if (csn_s) begin
            d.cnt      = 5'h00;
            d.is_read  = 1'b0;
            d.sdo_oe_n = 1'b1;
        end else begin
            if (q.req.rd) begin
                d.sh_out = rd_data;
            end
            if (sclk_s && !q.sclk_prev && q.cnt != `SSCR_FRAME_BITS) begin
                d.sh_in = {q.sh_in[21:0], sdi_s};
                d.cnt   = q.cnt + 5'h01;
                if (q.cnt == `SSCR_HDR_BITS - 5'h01) begin
                    d.is_read  = q.sh_in[14];
                    d.req.rd   = q.sh_in[14];
                    d.req.addr = {q.sh_in[13:0], sdi_s};
                end
                if (q.cnt == `SSCR_FRAME_BITS - 5'h01 && !q.is_read) begin
                    d.req.wr    = 1'b1;
                    d.req.wdata = {q.sh_in[6:0], sdi_s};
                end
            end
            if (!sclk_s && q.sclk_prev && q.is_read) begin
                d.sdo      = q.sh_out[7];
                d.sh_out   = {q.sh_out[6:0], 1'b0};
                d.sdo_oe_n = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q          <= '0;
            q.sync1    <= 3'h4;
            q.sync2    <= 3'h4;
            q.sdo_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sdo      = q.sdo;
    assign sdo_oe_n = q.sdo_oe_n;
    assign req      = q.req;

endmodule
`default_nettype wire

// ==== sscr_regs.sv ====
/*
 Configuration register bank of the sampling synthesizer: operating mode,
 timestamp receiver enable, reference output enable, feedback dividers.
 Assumes a serial control port on pins and a synthesizer enable from the
 core on clk_sys.
*/
// Operation
// R01: Mode code 0x46 is low power, 0x4b high performance, reset 0x4b, others reserved.
// R02: Software picks low power only at or below one gigasample per second.
// R03: Software writes mode with its three companion registers together.
// R04: Software calibrates the converter after every mode change.
// R05: Software clears calibration and serial link enables before writing mode.
// R06: Timestamp bit 0 enables the timestamp receiver, reset clear.
// R07: Reference output active only with its enable and synth enable; enable resets set.
// R08: Second divider bits 3:2 give divide 1, 2, 4; code 3 reserved.
// R09: First divider bits 1:0 give divide 5, 4, 3; code 3 reserved.
// R10: Third divider bits 5:0 divide by their value 1 to 63, reset 32.
// R11: Software asserts synth reset before changing any feedback divider.
// R12: Reserved bits kept as written, read back, no effect.
// R13: Every register reads back its last write or its reset value.
`timescale 1ns/1ps
`default_nettype none
`include "sscr_params.svh"

module sscr_regs #(
    parameter int ADDR_W = `SSCR_ADDR_W
) (
    input  wire logic                  clk_sys,                 // System clock
    input  wire logic                  reset,                   // Synchronous reset
    input  wire logic                  sclk,                    // Serial clock pin
    input  wire logic                  csn,                     // Chip select pin, low active
    input  wire logic                  sdi,                     // Serial data in pin
    output logic                       sdo,                     // Serial data out
    output logic                       sdo_oe_n,                // Low while sdo drives
    input  wire logic                  synth_enable,            // Synthesizer enabled
    output sscr_pkg::sscr_mode_cfg_t   mode_cfg,                // Operating mode setting
    output sscr_pkg::sscr_synth_cfg_t  synth_cfg,               // Feedback divider ratios
    output logic                       timestamp_receiver_enable, // Timestamp input on
    output logic                       ref_output_enable,       // Stored output enable
    output logic                       reference_clock_output   // Reference output active
);

    // ==========================================================
    // Parameter check
    if (ADDR_W != `SSCR_ADDR_W) begin : g_bad_addr_w
        $error("sscr_regs: address width must be 15");
    end

    sscr_pkg::sscr_regs_st_t q;
    sscr_pkg::sscr_regs_st_t d;
    sscr_pkg::sscr_req_t     req;
    logic [7:0]              rd_data;

    // ==========================================================
    // Decoding functions
    function automatic logic [7:0] read_mux(input logic [`SSCR_ADDR_W-1:0] a,
                                            input sscr_pkg::sscr_regs_st_t s);
        case (a)
            `SSCR_OFS_MODE:    read_mux = s.mode;
            `SSCR_OFS_TSTAMP:  read_mux = s.tstamp;
            `SSCR_OFS_REFO:    read_mux = s.refo;
            `SSCR_OFS_FBDIV12: read_mux = s.fbdiv12;
            `SSCR_OFS_FBDIV3:  read_mux = s.fbdiv3;
            default:           read_mux = 8'h00;
        endcase
    endfunction

    function automatic logic [2:0] first_ratio(input logic [1:0] c);
        case (c)
            2'h0:    first_ratio = 3'h5;
            2'h1:    first_ratio = 3'h4;
            2'h2:    first_ratio = 3'h3;
            default: first_ratio = 3'h0;
        endcase
    endfunction

    function automatic logic [2:0] second_ratio(input logic [1:0] c);
        case (c)
            2'h0:    second_ratio = 3'h1;
            2'h1:    second_ratio = 3'h2;
            2'h2:    second_ratio = 3'h4;
            default: second_ratio = 3'h0;
        endcase
    endfunction

    // ==========================================================
    // Serial port
    sscr_spi_slave u_spi (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .sclk     (sclk),
        .csn      (csn),
        .sdi      (sdi),
        .sdo      (sdo),
        .sdo_oe_n (sdo_oe_n),
        .req      (req),
        .rd_data  (rd_data)
    );

    assign rd_data = read_mux(req.addr, q); // R13

    // ==========================================================
    // Register writes and decoded settings
    always_comb begin
        d = q;
        if (req.wr) begin
            case (req.addr)
                `SSCR_OFS_MODE:    d.mode    = req.wdata; // R12
                `SSCR_OFS_TSTAMP:  d.tstamp  = req.wdata;
                `SSCR_OFS_REFO:    d.refo    = req.wdata;
                `SSCR_OFS_FBDIV12: d.fbdiv12 = req.wdata;
                `SSCR_OFS_FBDIV3:  d.fbdiv3  = req.wdata;
                default:           d.mode    = q.mode;
            endcase
        end
        d.mode_cfg.code      = d.mode;
        d.mode_cfg.low_power = (d.mode == `SSCR_MODE_LOWPWR); // R01
        d.mode_cfg.high_perf = (d.mode == `SSCR_MODE_HIPERF); // R01
        d.mode_cfg.reserved  = !d.mode_cfg.low_power && !d.mode_cfg.high_perf; // R01
        d.ts_recv_en         = d.tstamp[`SSCR_TS_RECV_BIT]; // R06
        d.refo_active        = d.refo[`SSCR_REFO_EN_BIT] && synth_enable; // R07
        d.synth_cfg.first_ratio     = first_ratio(d.fbdiv12[`SSCR_V_MSB:`SSCR_V_LSB]); // R09
        d.synth_cfg.first_reserved  = (d.fbdiv12[`SSCR_V_MSB:`SSCR_V_LSB] == 2'h3); // R09
        d.synth_cfg.second_ratio    = second_ratio(d.fbdiv12[`SSCR_P_MSB:`SSCR_P_LSB]); // R08
        d.synth_cfg.second_reserved = (d.fbdiv12[`SSCR_P_MSB:`SSCR_P_LSB] == 2'h3); // R08
        d.synth_cfg.third_ratio     = d.fbdiv3[`SSCR_N_MSB:`SSCR_N_LSB]; // R10
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q                           <= '0;
            q.mode                      <= `SSCR_RST_MODE; // R01
            q.tstamp                    <= `SSCR_RST_TSTAMP; // R06
            q.refo                      <= `SSCR_RST_REFO; // R07
            q.fbdiv12                   <= `SSCR_RST_FBDIV12;
            q.fbdiv3                    <= `SSCR_RST_FBDIV3; // R10
            q.mode_cfg.code             <= `SSCR_RST_MODE;
            q.mode_cfg.high_perf        <= 1'b1;
            q.synth_cfg.first_ratio     <= 3'h5;
            q.synth_cfg.second_ratio    <= 3'h1;
            q.synth_cfg.third_ratio     <= 6'h20;
        end else begin
            q <= d;
        end
    end

    assign mode_cfg                  = q.mode_cfg;
    assign synth_cfg                 = q.synth_cfg;
    assign timestamp_receiver_enable = q.ts_recv_en;
    assign ref_output_enable         = q.refo[`SSCR_REFO_EN_BIT];
    assign reference_clock_output    = q.refo_active;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_mode_code;
        logic [7:0] v;
        (req.wr && req.addr == `SSCR_OFS_MODE, v = req.wdata) |=>
            mode_cfg.code == v && mode_cfg.low_power == (v == 8'h46) && mode_cfg.high_perf == (v == 8'h4b);
    endproperty
    a_mode_code: assert property (p_mode_code) else $error("mode decode wrong"); // R01

    property p_tstamp;
        (req.wr && req.addr == `SSCR_OFS_TSTAMP) |=> timestamp_receiver_enable == $past(req.wdata[0]);
    endproperty
    a_tstamp: assert property (p_tstamp) else $error("timestamp enable wrong"); // R06

    property p_refo;
        !$past(reset) |-> reference_clock_output == (ref_output_enable && $past(synth_enable));
    endproperty
    a_refo: assert property (p_refo) else $error("reference output active without enables"); // R07

    property p_second_div;
        (req.wr && req.addr == `SSCR_OFS_FBDIV12 && req.wdata[3:2] == 2'h2) |=>
            synth_cfg.second_ratio == 3'h4 && !synth_cfg.second_reserved;
    endproperty
    a_second_div: assert property (p_second_div) else $error("second divider wrong"); // R08

    property p_first_div;
        (req.wr && req.addr == `SSCR_OFS_FBDIV12 && req.wdata[1:0] == 2'h0) |=>
            synth_cfg.first_ratio == 3'h5 && !synth_cfg.first_reserved;
    endproperty
    a_first_div: assert property (p_first_div) else $error("first divider wrong"); // R09

    property p_first_rsvd;
        (req.wr && req.addr == `SSCR_OFS_FBDIV12 && req.wdata[1:0] == 2'h3) |=>
            synth_cfg.first_ratio == 3'h0 && synth_cfg.first_reserved;
    endproperty
    a_first_rsvd: assert property (p_first_rsvd) else $error("first divider reserved code wrong"); // R09

    property p_second_rsvd;
        (req.wr && req.addr == `SSCR_OFS_FBDIV12 && req.wdata[3:2] == 2'h3) |=>
            synth_cfg.second_ratio == 3'h0 && synth_cfg.second_reserved;
    endproperty
    a_second_rsvd: assert property (p_second_rsvd) else $error("second divider reserved code wrong"); // R08

    // Timestamp enable and mode move only on a write to their own register
    property p_tstamp_hold;
        !(req.wr && req.addr == `SSCR_OFS_TSTAMP) |=> $stable(timestamp_receiver_enable);
    endproperty
    a_tstamp_hold: assert property (p_tstamp_hold) else $error("timestamp enable changed without write"); // R06

    property p_mode_hold;
        !(req.wr && req.addr == `SSCR_OFS_MODE) |=> $stable(mode_cfg);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write"); // R13

    property p_third_div;
        (req.wr && req.addr == `SSCR_OFS_FBDIV3) |=> synth_cfg.third_ratio == $past(req.wdata[5:0]);
    endproperty
    a_third_div: assert property (p_third_div) else $error("third divider wrong"); // R10

    property p_readback;
        logic [7:0] v;
        (req.wr && req.addr == `SSCR_OFS_REFO, v = req.wdata) ##1 (!req.wr)[*2] |->
            read_mux(`SSCR_OFS_REFO, q) == v;
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong"); // R13

    c_low_power: cover property (mode_cfg.low_power);
    c_n_max:     cover property (synth_cfg.third_ratio == 6'h3f);
    c_read:      cover property (req.rd && req.addr == `SSCR_OFS_FBDIV3);
    c_refo_held: cover property (ref_output_enable && !reference_clock_output);
    c_mode_rsvd: cover property (mode_cfg.reserved);

endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
 Self-checking bench of the sampling-synthesizer configuration registers.
 Assumes sscr_pkg and sscr_params.svh compiled first; drives the serial pins directly.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sscr_params.svh"

module tb_top;
    logic                      clk_sys;
    logic                      reset;
    logic                      sclk;
    logic                      csn;
    logic                      sdi;
    logic                      sdo;
    logic                      sdo_oe_n;
    logic                      synth_enable;
    sscr_pkg::sscr_mode_cfg_t  mode_cfg;
    sscr_pkg::sscr_synth_cfg_t synth_cfg;
    logic                      ts_en;
    logic                      refo_en;
    logic                      refo_out;
    int                        miscompares;
    int                        n_checks;

    sscr_regs i_dut (
        .clk_sys                   (clk_sys),
        .reset                     (reset),
        .sclk                      (sclk),
        .csn                       (csn),
        .sdi                       (sdi),
        .sdo                       (sdo),
        .sdo_oe_n                  (sdo_oe_n),
        .synth_enable              (synth_enable),
        .mode_cfg                  (mode_cfg),
        .synth_cfg                 (synth_cfg),
        .timestamp_receiver_enable (ts_en),
        .ref_output_enable         (refo_en),
        .reference_clock_output    (refo_out)
    );

    // ==========================================================
    // Clock, watchdog and report
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        miscompares++;
        wrap_up();
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask

    // ==========================================================
    // Serial frame: nb bits sent, sclk low 7 cycles then high 6 cycles per bit
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, input int nb,
                        output logic [7:0] rdat);
        logic [23:0] fr;
        fr = {rd, a, wd};
        rdat = 8'h00;
        csn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        for (int i = 23; i >= 24 - nb; i--) begin
            sdi <= fr[i];
            repeat (6) @(posedge clk_sys);
            @(negedge clk_sys);
            if (rd && i < 8) begin
                rdat[i] = sdo;
                chk1(sdo_oe_n, 1'b0, "sdo enable in data phase");
            end
            @(posedge clk_sys);
            sclk <= 1'b1;
            repeat (6) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (6) @(posedge clk_sys);
        csn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk1(sdo_oe_n, 1'b1, "sdo enable after frame");
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] unused;
        xfer(1'b0, a, d, 24, unused);
    endtask

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] d;
        xfer(1'b1, a, 8'h00, 24, d);
        chk8(d, exp, "register read back");
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd_chk(15'h0037, 8'h4b);
        rd_chk(15'h003b, 8'h00);
        rd_chk(15'h003c, 8'h01);
        rd_chk(15'h003d, 8'h00);
        rd_chk(15'h003e, 8'h20);
        chk8(mode_cfg.code, 8'h4b, "reset mode code");
        chk1(mode_cfg.high_perf, 1'b1, "reset high perf");
        chk1(ts_en, 1'b0, "reset timestamp enable");
        chk1(refo_out, 1'b1, "reference out without writes");
        chk8({5'h0, synth_cfg.first_ratio}, 8'h05, "reset first ratio");
        chk8({5'h0, synth_cfg.second_ratio}, 8'h01, "reset second ratio");
        chk8({2'h0, synth_cfg.third_ratio}, 8'h20, "reset third ratio");
    endtask

    // Mode writes keep calibration and link disabled; the bench has no such ports
    task automatic t_mode();
        logic [7:0] codes [5] = '{8'h46, 8'h4b, 8'h00, 8'h47, 8'hff};
        foreach (codes[k]) begin
            wr(15'h0037, codes[k]);
            chk8(mode_cfg.code, codes[k], "mode code");
            chk1(mode_cfg.low_power, codes[k] == 8'h46, "low power flag");
            chk1(mode_cfg.high_perf, codes[k] == 8'h4b, "high perf flag");
            chk1(mode_cfg.reserved, codes[k] != 8'h46 && codes[k] != 8'h4b, "mode reserved");
            rd_chk(15'h0037, codes[k]);
        end
    endtask

    // Divider changes assume synth reset held by software
    task automatic t_div12();
        logic [2:0] v_exp [4] = '{3'd5, 3'd4, 3'd3, 3'd0};
        logic [2:0] p_exp [4] = '{3'd1, 3'd2, 3'd4, 3'd0};
        for (int p = 0; p < 4; p++) begin
            for (int v = 0; v < 4; v++) begin
                wr(15'h003d, {4'h9, p[1:0], v[1:0]});
                chk8({5'h0, synth_cfg.first_ratio}, {5'h0, v_exp[v]}, "first ratio");
                chk1(synth_cfg.first_reserved, v == 3, "first reserved");
                chk8({5'h0, synth_cfg.second_ratio}, {5'h0, p_exp[p]}, "second ratio");
                chk1(synth_cfg.second_reserved, p == 3, "second reserved");
                rd_chk(15'h003d, {4'h9, p[1:0], v[1:0]});
            end
        end
    endtask

    task automatic t_div3();
        logic [7:0] vals [4] = '{8'hc1, 8'h3f, 8'h60, 8'h20};
        foreach (vals[k]) begin
            wr(15'h003e, vals[k]);
            chk8({2'h0, synth_cfg.third_ratio}, {2'h0, vals[k][5:0]}, "third ratio");
            rd_chk(15'h003e, vals[k]);
        end
    endtask

    task automatic t_ts_refo();
        wr(15'h003b, 8'hfd);
        chk1(ts_en, 1'b1, "timestamp enable set");
        wr(15'h003b, 8'h02);
        chk1(ts_en, 1'b0, "timestamp enable clear");
        rd_chk(15'h003b, 8'h02);
        synth_enable <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk1(refo_out, 1'b0, "reference out with synth off");
        chk1(refo_en, 1'b1, "stored enable kept");
        wr(15'h003c, 8'hfe);
        synth_enable <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk1(refo_out, 1'b0, "reference out with bit clear");
        chk1(refo_en, 1'b0, "stored enable clear");
        wr(15'h003c, 8'h81);
        chk1(refo_out, 1'b1, "reference out both on");
        rd_chk(15'h003c, 8'h81);
    endtask

    task automatic t_refused();
        logic [7:0] unused;
        wr(15'h0040, 8'h55);
        rd_chk(15'h0040, 8'h00);
        xfer(1'b0, 15'h003e, 8'h05, 12, unused);
        rd_chk(15'h003e, 8'h20);
        chk8({2'h0, synth_cfg.third_ratio}, 8'h20, "cut frame ignored");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        miscompares = 0;
        n_checks = 0;
        reset = 1'b1;
        sclk = 1'b0;
        csn = 1'b1;
        sdi = 1'b0;
        synth_enable = 1'b1;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_mode();
        t_div12();
        t_div3();
        t_ts_refo();
        t_refused();
        wrap_up();
    end
endmodule
`default_nettype wire
